// ---- rtl/kli_pkg.sv ----
package kli_pkg;

   // special-function bus addresses
   localparam logic [7:0] ADDR_LEVEL_SELECT = 8'h9c;
   localparam logic [7:0] ADDR_LINE_ENABLE = 8'h9d;
   localparam logic [7:0] ADDR_LINE_FLAGS = 8'h9e;
   localparam logic [7:0] ADDR_EXT_IRQ_ENABLE = 8'hb1;

   // widths and reset values
   localparam int NUM_LINES = 8;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [7:0] PIN_IDLE_BYTE = 8'hff; // pulled-up idle port level
   localparam int GLOBAL_EN_BIT = 0;

   // special-function bus request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } kli_sfr_req_t;

   // block state
   typedef struct packed {
      logic [7:0] level_select;
      logic [7:0] line_enable;
      logic [7:0] line_flags;
      logic global_en;
      logic [7:0] rdata;
      logic irq;
   } kli_state_t;

   // synchroniser state
   typedef struct packed {
      logic [7:0] meta;
      logic [7:0] sync;
   } kli_sync_t;

endpackage

// ---- rtl/kli_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
// two-stage synchroniser for the port pins
module kli_sync (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // pins in, synchronised out
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_sync
);

   kli_pkg::kli_sync_t st_ff;
   kli_pkg::kli_sync_t nxt_st;

   // first stage feeds only the second stage
   always_comb begin
      nxt_st.meta = pin_in;
      nxt_st.sync = st_ff.meta;
   end

   // state register; resets to the pins' pulled-up idle level so that
   // no line looks active before the pins have been sampled
   always_ff @(posedge clk) begin
      if (srst) begin
         st_ff.meta <= kli_pkg::PIN_IDLE_BYTE;
         st_ff.sync <= kli_pkg::PIN_IDLE_BYTE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pin_sync = st_ff.sync;

endmodule
`default_nettype wire

// ---- rtl/kli_keypad.sv ----
`timescale 1ns/1ns
`default_nettype none
module kli_keypad (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // special-function bus
   input wire kli_pkg::kli_sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   // keypad port pins
   input wire logic [7:0] keypad_port,
   // request to the core
   output logic keypad_irq_request
);

   kli_pkg::kli_state_t st_ff;
   kli_pkg::kli_state_t nxt_st;
   logic [7:0] port_sync;
   logic [7:0] detect;

   // function: is this address one of ours
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == kli_pkg::ADDR_LEVEL_SELECT) ||
                  (a == kli_pkg::ADDR_LINE_ENABLE) ||
                  (a == kli_pkg::ADDR_LINE_FLAGS) ||
                  (a == kli_pkg::ADDR_EXT_IRQ_ENABLE);
   endfunction

   // pins cross into the core clock
   kli_sync u_sync (
      .clk(clk),
      .srst(srst),
      .pin_in(keypad_port),
      .pin_sync(port_sync)
   );

   // per-line level match; xnor with the select bit
   assign detect = ~(port_sync ^ st_ff.level_select);

   // next-state logic
   always_comb begin
      nxt_st = st_ff;
      nxt_st.rdata = kli_pkg::ZERO_BYTE;
      // register writes
      if (sfr_req.wr) begin
         unique case (sfr_req.addr)
            kli_pkg::ADDR_LEVEL_SELECT: begin
               nxt_st.level_select = sfr_req.wdata;
            end
            kli_pkg::ADDR_LINE_ENABLE: begin
               nxt_st.line_enable = sfr_req.wdata;
            end
            kli_pkg::ADDR_LINE_FLAGS: begin
               nxt_st.line_flags = sfr_req.wdata;
            end
            kli_pkg::ADDR_EXT_IRQ_ENABLE: begin
               nxt_st.global_en = sfr_req.wdata[kli_pkg::GLOBAL_EN_BIT];
            end
            default: begin
            end
         endcase
      end
      // hardware set wins over software clear
      nxt_st.line_flags = nxt_st.line_flags | detect;
      // register reads, answered from the registered copy
      if (sfr_req.rd) begin
         unique case (sfr_req.addr)
            kli_pkg::ADDR_LEVEL_SELECT: begin
               nxt_st.rdata = st_ff.level_select;
            end
            kli_pkg::ADDR_LINE_ENABLE: begin
               nxt_st.rdata = st_ff.line_enable;
            end
            kli_pkg::ADDR_LINE_FLAGS: begin
               nxt_st.rdata = st_ff.line_flags;
            end
            kli_pkg::ADDR_EXT_IRQ_ENABLE: begin
               nxt_st.rdata = {7'h00, st_ff.global_en};
            end
            default: begin
               nxt_st.rdata = kli_pkg::ZERO_BYTE;
            end
         endcase
      end
      // disabled lines give nothing; one shared gated request
      nxt_st.irq = st_ff.global_en &
                   (|(st_ff.line_flags & st_ff.line_enable));
   end

   // state register
   always_ff @(posedge clk) begin
      if (srst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs
   assign sfr_rdata = st_ff.rdata;
   assign sfr_hit = is_mapped(sfr_req.addr) & (sfr_req.rd | sfr_req.wr);
   assign keypad_irq_request = st_ff.irq;

   // detection: a line at its selected level shows in its flag
   flag_sets_a: assert property (@(posedge clk) disable iff (srst)
      ##1 1'b1 |-> ((st_ff.line_flags & $past(detect)) == $past(detect)))
      else $error("detected line flag not set");
   sync_path_a: assert property (@(posedge clk) disable iff (srst)
      ##2 1'b1 |-> (port_sync == $past(keypad_port, 2)))
      else $error("pin level lost in synchroniser");
   low_detect_a: assert property (@(posedge clk) disable iff (srst)
      (!st_ff.level_select[0] && !port_sync[0]) |=> st_ff.line_flags[0])
      else $error("low level not detected");
   low_line3_a: assert property (@(posedge clk) disable iff (srst)
      (!st_ff.level_select[3] && !port_sync[3]) |=> st_ff.line_flags[3])
      else $error("low level not detected on line three");
   high_detect_a: assert property (@(posedge clk) disable iff (srst)
      (st_ff.level_select[0] && port_sync[0]) |=> st_ff.line_flags[0])
      else $error("high level not detected");
   high_line7_a: assert property (@(posedge clk) disable iff (srst)
      (st_ff.level_select[7] && port_sync[7]) |=> st_ff.line_flags[7])
      else $error("high level not detected on line seven");
   no_high_a: assert property (@(posedge clk) disable iff (srst)
      (!sfr_req.wr && !st_ff.level_select[0] && port_sync[0] &&
       !st_ff.line_flags[0]) |=> !st_ff.line_flags[0])
      else $error("high level set a low-select flag");
   no_low_a: assert property (@(posedge clk) disable iff (srst)
      (!sfr_req.wr && st_ff.level_select[0] && !port_sync[0] &&
       !st_ff.line_flags[0]) |=> !st_ff.line_flags[0])
      else $error("low level set a high-select flag");

   // flags: hardware only sets them, a write loads them with detected lines kept set
   flag_hold_a: assert property (@(posedge clk) disable iff (srst)
      !sfr_req.wr |=> ((st_ff.line_flags & $past(st_ff.line_flags))
         == $past(st_ff.line_flags)))
      else $error("flag cleared without software");
   flag_only_a: assert property (@(posedge clk) disable iff (srst)
      !sfr_req.wr |=> (st_ff.line_flags ==
         ($past(st_ff.line_flags) | $past(detect))))
      else $error("flag set with no level on its line");
   flag_write_a: assert property (@(posedge clk) disable iff (srst)
      (sfr_req.wr && sfr_req.addr == kli_pkg::ADDR_LINE_FLAGS) |=>
         (st_ff.line_flags == ($past(sfr_req.wdata) | $past(detect))))
      else $error("flag write not applied");
   reset_again_a: assert property (@(posedge clk) disable iff (srst)
      (sfr_req.wr && sfr_req.addr == kli_pkg::ADDR_LINE_FLAGS &&
       sfr_req.wdata == kli_pkg::ZERO_BYTE && detect[3])
      |=> st_ff.line_flags[3])
      else $error("held level lost on clear");

   // request: enabled flags, under the global enable, on one line
   req_gate_a: assert property (@(posedge clk) disable iff (srst)
      ##1 1'b1 |-> (keypad_irq_request == ($past(st_ff.global_en) &
         (|($past(st_ff.line_flags) & $past(st_ff.line_enable))))))
      else $error("request does not follow gated flags");
   irq_drop_a: assert property (@(posedge clk) disable iff (srst)
      !(|(st_ff.line_flags & st_ff.line_enable)) |=> !keypad_irq_request)
      else $error("request with no enabled flag");
   disabled_quiet_a: assert property (@(posedge clk) disable iff (srst)
      (st_ff.line_enable == kli_pkg::ZERO_BYTE) |=> !keypad_irq_request)
      else $error("request with no lines enabled");
   global_gate_a: assert property (@(posedge clk) disable iff (srst)
      !st_ff.global_en |=> !keypad_irq_request)
      else $error("request despite global disable");
   shared_req_a: assert property (@(posedge clk) disable iff (srst)
      (st_ff.global_en && (|(st_ff.line_flags & st_ff.line_enable)))
      |=> keypad_irq_request)
      else $error("enabled flag gave no request");

   // register bus: writes land on the next edge, reads answer a cycle later
   select_write_a: assert property (@(posedge clk) disable iff (srst)
      (sfr_req.wr && sfr_req.addr == kli_pkg::ADDR_LEVEL_SELECT)
      |=> (st_ff.level_select == $past(sfr_req.wdata)))
      else $error("level select write lost");
   enable_write_a: assert property (@(posedge clk) disable iff (srst)
      (sfr_req.wr && sfr_req.addr == kli_pkg::ADDR_LINE_ENABLE)
      |=> (st_ff.line_enable == $past(sfr_req.wdata)))
      else $error("line enable write lost");
   global_write_a: assert property (@(posedge clk) disable iff (srst)
      (sfr_req.wr && sfr_req.addr == kli_pkg::ADDR_EXT_IRQ_ENABLE)
      |=> (st_ff.global_en == $past(sfr_req.wdata[kli_pkg::GLOBAL_EN_BIT])))
      else $error("global enable write lost");
   unmapped_wr_a: assert property (@(posedge clk) disable iff (srst)
      (sfr_req.wr && !is_mapped(sfr_req.addr)) |=>
         ((st_ff.line_enable == $past(st_ff.line_enable)) &&
          (st_ff.level_select == $past(st_ff.level_select))))
      else $error("unmapped write changed a register");
   flags_read_a: assert property (@(posedge clk) disable iff (srst)
      (sfr_req.rd && sfr_req.addr == kli_pkg::ADDR_LINE_FLAGS)
      |=> (sfr_rdata == $past(st_ff.line_flags)))
      else $error("flag read returned wrong value");
   enable_read_a: assert property (@(posedge clk) disable iff (srst)
      (sfr_req.rd && sfr_req.addr == kli_pkg::ADDR_LINE_ENABLE)
      |=> (sfr_rdata == $past(st_ff.line_enable)))
      else $error("line enable read returned wrong value");
   select_read_a: assert property (@(posedge clk) disable iff (srst)
      (sfr_req.rd && sfr_req.addr == kli_pkg::ADDR_LEVEL_SELECT)
      |=> (sfr_rdata == $past(st_ff.level_select)))
      else $error("level select read returned wrong value");
   global_read_a: assert property (@(posedge clk) disable iff (srst)
      (sfr_req.rd && sfr_req.addr == kli_pkg::ADDR_EXT_IRQ_ENABLE)
      |=> (sfr_rdata[kli_pkg::GLOBAL_EN_BIT] == $past(st_ff.global_en)))
      else $error("global enable read returned wrong value");

   // scenarios worth seeing
   irq_seen_c: cover property (@(posedge clk) disable iff (srst)
      keypad_irq_request);
   clear_c: cover property (@(posedge clk) disable iff (srst)
      sfr_req.wr && sfr_req.addr == kli_pkg::ADDR_LINE_FLAGS);
   high_sel_c: cover property (@(posedge clk) disable iff (srst)
      st_ff.level_select[0] && st_ff.line_flags[0]);
   multi_line_c: cover property (@(posedge clk) disable iff (srst)
      st_ff.line_flags[7] && st_ff.line_flags[0]);
   rearm_c: cover property (@(posedge clk) disable iff (srst)
      sfr_req.wr && sfr_req.addr == kli_pkg::ADDR_LINE_FLAGS && (|detect));

endmodule
`default_nettype wire

// ---- test/kli_matrix.sv ----
`timescale 1ns/1ns
`default_nettype none
// keypad matrix: a pressed key pulls its line low
module kli_matrix (
   // keys held down by the bench
   input wire logic [7:0] key_down,
   // port lines
   output logic [7:0] lines
);
   // pull-ups hold idle lines high
   assign lines = ~key_down;
endmodule
`default_nettype wire

// ---- test/tb_keypad_level_interrupt.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_keypad_level_interrupt;
   logic clk = 1'b0;
   logic srst = 1'b1;
   kli_pkg::kli_sfr_req_t req = '0;
   logic [7:0] rdata, port;
   logic [7:0] keys = 8'h00;
   logic hit, irq;
   int failures = 0, n_compared = 0, cycles = 0;
   kli_matrix mtx (.key_down(keys), .lines(port));
   kli_keypad dut (.clk(clk), .srst(srst), .sfr_req(req),
      .sfr_rdata(rdata), .sfr_hit(hit), .keypad_port(port),
      .keypad_irq_request(irq));
   // clock and hang guard
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 1000) begin
         failures++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic idle(int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(negedge clk);
      req <= '{wr:1'b1, rd:1'b0, addr:a, wdata:d};
      @(negedge clk);
      req.wr <= 1'b0;
   endtask
   // read strobe, decode check, data one cycle later
   task automatic rd(logic [7:0] a, logic [7:0] exp);
      @(negedge clk);
      req <= '{wr:1'b0, rd:1'b1, addr:a, wdata:8'h00};
      #1 chk("hit", {7'h00, hit},
         {7'h00, (a inside {8'h9c, 8'h9d, 8'h9e, 8'hb1})});
      @(negedge clk);
      req.rd <= 1'b0;
      chk("rdata", rdata, exp);
   endtask
   task automatic t_reset();
      idle(4);
      rd(8'h9c, 8'h00);
      rd(8'h9d, 8'h00);
      rd(8'h9e, 8'h00);
      rd(8'hb1, 8'h00);
      rd(8'h9f, 8'h00);
      wr(8'h9f, 8'hff);
      rd(8'h9d, 8'h00);
   endtask
   task automatic t_low_detect();
      keys <= 8'h08;
      idle(5);
      rd(8'h9e, 8'h08);
      chk("irq", {7'h00, irq}, 8'h00);
      wr(8'h9e, 8'h00);
      rd(8'h9e, 8'h08);
      keys <= 8'h00;
      idle(5);
      rd(8'h9e, 8'h08);
      wr(8'h9e, 8'h00);
      rd(8'h9e, 8'h00);
   endtask
   task automatic t_high_detect();
      keys <= 8'h01;
      wr(8'h9c, 8'h81);
      idle(5);
      rd(8'h9e, 8'h80);
      keys <= 8'h00;
      idle(5);
      rd(8'h9e, 8'h81);
      wr(8'h9c, 8'h00);
      wr(8'h9e, 8'h00);
      rd(8'h9e, 8'h00);
   endtask
   task automatic t_irq_gate();
      keys <= 8'h20;
      wr(8'h9d, 8'h20);
      idle(5);
      chk("irq", {7'h00, irq}, 8'h00);
      wr(8'hb1, 8'hff);
      idle(3);
      chk("irq", {7'h00, irq}, 8'h01);
      rd(8'hb1, 8'h01);
      wr(8'h9d, 8'h10);
      idle(3);
      chk("irq", {7'h00, irq}, 8'h00);
      keys <= 8'h00;
      wr(8'h9d, 8'h20);
      wr(8'h9e, 8'h00);
      idle(3);
      chk("irq", {7'h00, irq}, 8'h00);
   endtask
   // two lines feed the one shared request
   task automatic t_shared();
      keys <= 8'h81;
      wr(8'h9d, 8'h01);
      idle(5);
      rd(8'h9e, 8'h81);
      chk("irq", {7'h00, irq}, 8'h01);
      wr(8'h9d, 8'h80);
      idle(3);
      chk("irq", {7'h00, irq}, 8'h01);
      keys <= 8'h00;
      idle(5);
      wr(8'h9e, 8'h00);
      idle(3);
      chk("irq", {7'h00, irq}, 8'h00);
   endtask
   // main sequence
   initial begin
      idle(10);
      srst <= 1'b0;
      t_reset();
      t_low_detect();
      t_high_detect();
      t_irq_gate();
      t_shared();
      print_verdict();
   end
endmodule
`default_nettype wire
